// [logic/tcsp_port.sv]
// Control and status port: status pins, control pins, APB registers and interrupt
`timescale 1ns/1ps
`include "tcsp_consts.svh"

module tcsp_port
	import tcsp_pkg::*;
#(
	parameter int CHG_PULSE_CYC = `TCSP_CHG_PULSE_US * `TCSP_CLK_MHZ
)(
	// Clock and reset
	input  wire logic           SYS_CLK,
	input  wire logic           SRST,
	// APB slave
	input  wire tcsp_apb_req_s  APB_REQ,
	output      tcsp_apb_rsp_s  APB_RSP,
	// Rear panel pins
	input  wire tcsp_pins_in_s  PINS_IN,
	output      tcsp_pins_out_s PINS_OUT,
	// Instrument core
	input  wire logic           OUTPUT_CHANGED,
	input  wire logic           PROTECT,
	output      logic           OUTPUT_ENABLE,
	output      logic           TRANSIENT_START,
	// Interrupt
	output      logic           IRQ
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	localparam logic [`TCSP_CHG_CNT_W-1:0] CHG_LAST =
		`TCSP_CHG_CNT_W'(CHG_PULSE_CYC - 1);

	tcsp_state_s               state_reg;
	tcsp_state_s               state_next;

	logic [`TCSP_SYNC_W-1:0]   pins_raw;
	logic [`TCSP_SYNC_W-1:0]   pins_sync;

	logic                      inhibit_n;
	logic                      trigger_n;
	logic                      ext_sw_n;

	logic                      wr_access;
	logic                      rd_setup;
	logic                      cmd_on;
	logic                      cmd_off;
	logic                      cmd_clr_fault;
	logic                      trig_fall;
	logic                      chg_event;
	logic [`TCSP_IRQ_W-1:0]    irq_events;
	logic [`TCSP_IRQ_W-1:0]    irq_clear;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic addr_is(input logic [`TCSP_ADDR_W-1:0] addr,
	                                 input logic [`TCSP_ADDR_W-1:0] off);
		addr_is = (addr == off);
	endfunction

	function automatic logic addr_mapped(input logic [`TCSP_ADDR_W-1:0] addr);
		addr_mapped = addr_is(addr, `TCSP_OFF_CTRL)     ||
		              addr_is(addr, `TCSP_OFF_CMD)      ||
		              addr_is(addr, `TCSP_OFF_STATUS)   ||
		              addr_is(addr, `TCSP_OFF_IRQ_STAT) ||
		              addr_is(addr, `TCSP_OFF_IRQ_MASK);
	endfunction

	// Falling edge of a settled pin whose idle level is high
	function automatic logic fell_edge(input logic prev, input logic cur);
		fell_edge = prev & ~cur;
	endfunction

	// Read data; pin levels shown are the settled copies, never the raw pins
	function automatic logic [`TCSP_DATA_W-1:0] read_word(
		input logic [`TCSP_ADDR_W-1:0] addr,
		input tcsp_state_s             st,
		input logic                    inh_n,
		input logic                    ext_n
	);
		logic [`TCSP_DATA_W-1:0] word;
		word = '0;
		if (addr_is(addr, `TCSP_OFF_CTRL)) begin
			word[`TCSP_CTRL_PHASE3] = st.phase3;
			word[`TCSP_CTRL_SHORT]  = st.short_on;
			word[`TCSP_CTRL_FAULT]  = st.force_fault;
		end
		if (addr_is(addr, `TCSP_OFF_STATUS)) begin
			word[`TCSP_ST_ACTIVE]    = st.active;
			word[`TCSP_ST_HALT]      = st.halt;
			word[`TCSP_ST_FAULT]     = st.fault;
			word[`TCSP_ST_PHASE3]    = st.phase3;
			word[`TCSP_ST_INHIBIT_N] = inh_n;
			word[`TCSP_ST_EXT_SW_N]  = ext_n;
			word[`TCSP_ST_CHANGE]    = (st.chg == CHG_PULSE);
			word[`TCSP_ST_TRIG_LSB +: `TCSP_TRIG_CNT_W] = st.trig_cnt;
		end
		if (addr_is(addr, `TCSP_OFF_IRQ_STAT)) begin
			word[`TCSP_IRQ_W-1:0] = st.irq_stat;
		end
		if (addr_is(addr, `TCSP_OFF_IRQ_MASK)) begin
			word[`TCSP_IRQ_W-1:0] = st.irq_mask;
		end
		read_word = word;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	always_comb begin
		pins_raw                     = '0;
		pins_raw[`TCSP_SYNC_INHIBIT] = PINS_IN.inhibit_n;
		pins_raw[`TCSP_SYNC_TRIGGER] = PINS_IN.trigger_n;
		pins_raw[`TCSP_SYNC_EXT_SW]  = PINS_IN.external_output_switch_n;
	end

	tcsp_sync u_sync (
		.SYS_CLK (SYS_CLK),
		.SRST    (SRST),
		.RAW     (pins_raw),
		.SYNCED  (pins_sync)
	);

	assign inhibit_n = pins_sync[`TCSP_SYNC_INHIBIT];
	assign trigger_n = pins_sync[`TCSP_SYNC_TRIGGER];
	assign ext_sw_n  = pins_sync[`TCSP_SYNC_EXT_SW];

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	// Zero wait states: every access completes in its first access cycle
	assign wr_access = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
	assign rd_setup  = APB_REQ.psel & ~APB_REQ.penable & ~APB_REQ.pwrite;

	always_comb begin
		cmd_on        = 1'b0;
		cmd_off       = 1'b0;
		cmd_clr_fault = 1'b0;
		irq_clear     = '0;
		if (wr_access && addr_is(APB_REQ.paddr, `TCSP_OFF_CMD)) begin
			cmd_on        = APB_REQ.pwdata[`TCSP_CMD_ON];
			cmd_off       = APB_REQ.pwdata[`TCSP_CMD_OFF];
			cmd_clr_fault = APB_REQ.pwdata[`TCSP_CMD_CLR_FAULT];
		end
		if (wr_access && addr_is(APB_REQ.paddr, `TCSP_OFF_IRQ_STAT)) begin
			irq_clear = APB_REQ.pwdata[`TCSP_IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_next            = state_reg;
		state_next.trig_pulse = 1'b0;
		chg_event             = 1'b0;
		irq_events            = '0;

		// Control register
		if (wr_access && addr_is(APB_REQ.paddr, `TCSP_OFF_CTRL)) begin
			state_next.phase3      = APB_REQ.pwdata[`TCSP_CTRL_PHASE3];
			state_next.short_on    = APB_REQ.pwdata[`TCSP_CTRL_SHORT];
			state_next.force_fault = APB_REQ.pwdata[`TCSP_CTRL_FAULT];
		end

		// Interrupt mask register
		if (wr_access && addr_is(APB_REQ.paddr, `TCSP_OFF_IRQ_MASK)) begin
			state_next.irq_mask = APB_REQ.pwdata[`TCSP_IRQ_W-1:0];
		end

		// Halt is level sensitive and outranks a restart in the same cycle;
		// a restart while the pin is still low is therefore refused
		if (!inhibit_n) begin
			state_next.sw_on = 1'b0;
			state_next.halt  = 1'b1;
		end else if (cmd_on) begin
			state_next.sw_on = 1'b1;
			state_next.halt  = 1'b0;
		end else if (cmd_off) begin
			state_next.sw_on = 1'b0;
		end

		// Protection state holds until cleared with its cause gone
		if (PROTECT || state_next.force_fault) begin
			state_next.fault = 1'b1;
		end else if (cmd_clr_fault) begin
			state_next.fault = 1'b0;
		end

		// External switch high forces off without latching anything
		state_next.active = state_next.sw_on & ~state_next.halt &
		                    ~state_next.fault & ~ext_sw_n;

		// Transient trigger on a settled falling edge
		state_next.trig_prev = trigger_n;
		state_next.inh_prev  = inhibit_n;
		state_next.ext_prev  = ext_sw_n;
		if (trig_fall) begin
			state_next.trig_pulse = 1'b1;
			state_next.trig_cnt   = state_reg.trig_cnt + 1'b1;
		end

		// Output switching on or off counts as a change too; computed here so
		// that no path runs from the next state back into itself
		chg_event = (state_next.active != state_reg.active) |
		            OUTPUT_CHANGED | trig_fall;

		// Change pulse: a new change restarts the full low time
		if (chg_event) begin
			state_next.chg = CHG_PULSE;
			state_next.cnt = '0;
		end else begin
			unique case (state_reg.chg)
				CHG_IDLE: begin
					state_next.cnt = '0;
				end
				CHG_PULSE: begin
					if (state_reg.cnt == CHG_LAST) begin
						state_next.chg = CHG_IDLE;
						state_next.cnt = '0;
					end else begin
						state_next.cnt = state_reg.cnt + 1'b1;
					end
				end
				default: begin
					state_next.chg = CHG_IDLE;
					state_next.cnt = '0;
				end
			endcase
		end

		// Interrupt events from settled pins and the new fault state
		irq_events[`TCSP_IRQ_HALT]   = fell_edge(state_reg.inh_prev, inhibit_n);
		irq_events[`TCSP_IRQ_TRIG]   = trig_fall;
		irq_events[`TCSP_IRQ_EXT_SW] = state_reg.ext_prev ^ ext_sw_n;
		irq_events[`TCSP_IRQ_FAULT]  = state_next.fault & ~state_reg.fault;

		// Sticky interrupt status, an event wins over its clear
		state_next.irq_stat = (state_reg.irq_stat & ~irq_clear) | irq_events;
		state_next.irq      = |(state_next.irq_stat & state_next.irq_mask);

		// Read data is captured in the setup cycle, so it stands from a flip-flop
		// through the whole access cycle
		if (rd_setup) begin
			state_next.prdata = read_word(APB_REQ.paddr, state_reg, inhibit_n, ext_sw_n);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Events

	assign trig_fall = fell_edge(state_reg.trig_prev, trigger_n);

	////////////////////////////////////////////////////////////////////////////////
	// State register

	// Pin history resets to the idle high level so no edge is seen at release
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_reg           <= '0;
			state_reg.chg       <= CHG_IDLE;
			state_reg.inh_prev  <= 1'b1;
			state_reg.trig_prev <= 1'b1;
			state_reg.ext_prev  <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		PINS_OUT.change_n      = ~(state_reg.chg == CHG_PULSE);
		PINS_OUT.output_active = state_reg.active;
		PINS_OUT.phase_single  = ~state_reg.phase3;
		PINS_OUT.fault_n       = ~state_reg.fault;
		PINS_OUT.short_relay   = state_reg.short_on;
	end

	assign OUTPUT_ENABLE   = state_reg.active;
	assign TRANSIENT_START = state_reg.trig_pulse;
	assign IRQ             = state_reg.irq;

	always_comb begin
		APB_RSP.prdata  = state_reg.prdata;
		APB_RSP.pready  = 1'b1;
		APB_RSP.pslverr = APB_REQ.psel & APB_REQ.penable &
		                  ~addr_mapped(APB_REQ.paddr);
	end

endmodule

// [common/tcsp_consts.svh]
// Offsets, field positions, reset values and timing figures of the control and status port
`ifndef TCSP_CONSTS_SVH
`define TCSP_CONSTS_SVH

// Clock and change pulse timing
`define TCSP_CLK_MHZ         250
`define TCSP_CHG_PULSE_US    64
`define TCSP_CHG_CNT_W       16

// APB geometry
`define TCSP_ADDR_W          12
`define TCSP_DATA_W          32

// Register byte offsets
`define TCSP_OFF_CTRL        12'h000
`define TCSP_OFF_CMD         12'h004
`define TCSP_OFF_STATUS      12'h008
`define TCSP_OFF_IRQ_STAT    12'h00c
`define TCSP_OFF_IRQ_MASK    12'h010

// Control register fields
`define TCSP_CTRL_PHASE3     0
`define TCSP_CTRL_SHORT      1
`define TCSP_CTRL_FAULT      2

// Command register fields, write-only pulses
`define TCSP_CMD_ON          0
`define TCSP_CMD_OFF         1
`define TCSP_CMD_CLR_FAULT   2

// Status register fields
`define TCSP_ST_ACTIVE       0
`define TCSP_ST_HALT         1
`define TCSP_ST_FAULT        2
`define TCSP_ST_PHASE3       3
`define TCSP_ST_INHIBIT_N    4
`define TCSP_ST_EXT_SW_N     5
`define TCSP_ST_CHANGE       6
`define TCSP_ST_TRIG_LSB     8
`define TCSP_TRIG_CNT_W      8

// Interrupt status and mask fields
`define TCSP_IRQ_W           4
`define TCSP_IRQ_HALT        0
`define TCSP_IRQ_TRIG        1
`define TCSP_IRQ_EXT_SW      2
`define TCSP_IRQ_FAULT       3

// Synchroniser: three active-low inputs, idle high
`define TCSP_SYNC_W          3
`define TCSP_SYNC_RST        3'h7
`define TCSP_SYNC_INHIBIT    0
`define TCSP_SYNC_TRIGGER    1
`define TCSP_SYNC_EXT_SW     2

`endif

// [common/tcsp_pkg.sv]
// Types shared by the control and status port modules
`include "tcsp_consts.svh"

package tcsp_pkg;

	typedef struct packed {
		logic                     psel;
		logic                     penable;
		logic                     pwrite;
		logic [`TCSP_ADDR_W-1:0]  paddr;
		logic [`TCSP_DATA_W-1:0]  pwdata;
	} tcsp_apb_req_s;

	typedef struct packed {
		logic [`TCSP_DATA_W-1:0]  prdata;
		logic                     pready;
		logic                     pslverr;
	} tcsp_apb_rsp_s;

	typedef struct packed {
		logic inhibit_n;
		logic trigger_n;
		logic external_output_switch_n;
	} tcsp_pins_in_s;

	typedef struct packed {
		logic change_n;
		logic output_active;
		logic phase_single;
		logic fault_n;
		logic short_relay;
	} tcsp_pins_out_s;

	typedef enum logic [1:0] {
		CHG_IDLE  = 2'b01,
		CHG_PULSE = 2'b10
	} tcsp_chg_e;

	typedef struct packed {
		logic [`TCSP_SYNC_W-1:0] stage1;
		logic [`TCSP_SYNC_W-1:0] stage2;
	} tcsp_sync_s;

	typedef struct packed {
		tcsp_chg_e                   chg;
		logic [`TCSP_CHG_CNT_W-1:0]  cnt;
		logic                        sw_on;
		logic                        halt;
		logic                        fault;
		logic                        active;
		logic                        phase3;
		logic                        short_on;
		logic                        force_fault;
		logic                        inh_prev;
		logic                        trig_prev;
		logic                        ext_prev;
		logic                        trig_pulse;
		logic [`TCSP_TRIG_CNT_W-1:0] trig_cnt;
		logic [`TCSP_IRQ_W-1:0]      irq_stat;
		logic [`TCSP_IRQ_W-1:0]      irq_mask;
		logic                        irq;
		logic [`TCSP_DATA_W-1:0]     prdata;
	} tcsp_state_s;

endpackage

// [logic/tcsp_sync.sv]
// Two-stage synchroniser for the asynchronous control pins
`timescale 1ns/1ps
`include "tcsp_consts.svh"

module tcsp_sync
	import tcsp_pkg::*;
(
	// Clock and reset
	input  wire logic                    SYS_CLK,
	input  wire logic                    SRST,
	// Raw pins and their settled copy
	input  wire logic [`TCSP_SYNC_W-1:0] RAW,
	output      logic [`TCSP_SYNC_W-1:0] SYNCED
);

	tcsp_sync_s state_reg;
	tcsp_sync_s state_next;

	// Stage one feeds stage two only, nothing else looks at it
	always_comb begin
		state_next        = state_reg;
		state_next.stage1 = RAW;
		state_next.stage2 = state_reg.stage1;
	end

	// Idle level is high, so reset never fakes a falling edge
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_reg.stage1 <= `TCSP_SYNC_RST;
			state_reg.stage2 <= `TCSP_SYNC_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign SYNCED = state_reg.stage2;

endmodule

// [verification/tcsp_ctl_model.sv]
// Model of the external controller that drives the control pins
`timescale 1ns/1ps

module tcsp_ctl_model
	import tcsp_pkg::*;
(
	// Clock
	input  wire logic          SYS_CLK,
	// Wanted levels and trigger request from the bench
	input  wire logic          INH_LVL,
	input  wire logic          EXT_LVL,
	input  wire logic          TRIG_REQ,
	// Control pins of the port
	output      tcsp_pins_in_s PINS_IN
);
	tcsp_pins_in_s pins_reg = 3'h7;
	logic [3:0]    low_cnt  = 4'h0;

	assign PINS_IN = pins_reg;

	////////////////////////////////////////////////////////////////////////////
	// Levels are held as long as wanted; the trigger low time spans several
	// synchroniser cycles so the port always sees a clean high-to-low edge
	always @(posedge SYS_CLK) begin
		pins_reg.inhibit_n <= INH_LVL;
		pins_reg.external_output_switch_n <= EXT_LVL;
		if (TRIG_REQ) begin
			low_cnt <= 4'h6;
		end else if (low_cnt != 4'h0) begin
			low_cnt <= low_cnt - 4'h1;
		end
		pins_reg.trigger_n <= !(TRIG_REQ || low_cnt > 4'h1);
	end
endmodule

// [verification/tcsp_port_sva.sv]
// Checker of the control and status port pins
`timescale 1ns/1ps

module tcsp_port_sva
	import tcsp_pkg::*;
#(
	parameter int CHG_PULSE_CYC = 16000
)(
	// Clock and reset
	input  wire logic           SYS_CLK,
	input  wire logic           SRST,
	// APB
	input  wire tcsp_apb_req_s  APB_REQ,
	input  wire tcsp_apb_rsp_s  APB_RSP,
	// Pins
	input  wire tcsp_pins_in_s  PINS_IN,
	input  wire tcsp_pins_out_s PINS_OUT,
	// Core side
	input  wire logic           OUTPUT_CHANGED,
	input  wire logic           PROTECT,
	input  wire logic           OUTPUT_ENABLE,
	input  wire logic           TRANSIENT_START,
	input  wire logic           IRQ
);
	logic [15:0] low_cnt_reg;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	// Length of the current low run of the change pin
	always_ff @(posedge SYS_CLK) begin
		if (SRST || PINS_OUT.change_n) begin
			low_cnt_reg <= 16'h0;
		end else begin
			low_cnt_reg <= low_cnt_reg + 16'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	chg_start_a: assert property (OUTPUT_CHANGED |=> !PINS_OUT.change_n)
		else $error("change pin not low after change");
	chg_length_a: assert property ($rose(PINS_OUT.change_n) |->
		low_cnt_reg >= CHG_PULSE_CYC)
		else $error("change pulse too short");
	active_pin_a: assert property (PINS_OUT.output_active == OUTPUT_ENABLE)
		else $error("active pin differs from output enable");
	halt_stop_a: assert property (!PINS_IN.inhibit_n [*3] |=>
		!PINS_OUT.output_active)
		else $error("output not stopped by halt");
	ext_off_a: assert property (PINS_IN.external_output_switch_n [*4] |->
		!PINS_OUT.output_active)
		else $error("output on while switch high");
	fault_flag_a: assert property (PROTECT |=> !PINS_OUT.fault_n)
		else $error("fault flag not low in protection");
	fault_stop_a: assert property (PROTECT |=> !PINS_OUT.output_active)
		else $error("output on in protection");
	trig_start_a: assert property ($fell(PINS_IN.trigger_n) |->
		##3 TRANSIENT_START)
		else $error("transient not started by trigger edge");
	trig_pulse_a: assert property (TRANSIENT_START |->
		!PINS_OUT.change_n ##1 !TRANSIENT_START)
		else $error("transient start not a single pulse");
	act_change_a: assert property ($changed(PINS_OUT.output_active) |->
		!PINS_OUT.change_n)
		else $error("output switched without change pulse");
endmodule

bind tcsp_port tcsp_port_sva #(.CHG_PULSE_CYC(CHG_PULSE_CYC)) i_tcsp_port_sva (
	.SYS_CLK(SYS_CLK), .SRST(SRST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
	.PINS_IN(PINS_IN), .PINS_OUT(PINS_OUT), .OUTPUT_CHANGED(OUTPUT_CHANGED),
	.PROTECT(PROTECT), .OUTPUT_ENABLE(OUTPUT_ENABLE),
	.TRANSIENT_START(TRANSIENT_START), .IRQ(IRQ));

// [verification/tcsp_port_tb_top.sv]
// Self-checking testbench of the control and status port
`timescale 1ns/1ps
`include "tcsp_consts.svh"

module tcsp_port_tb_top
	import tcsp_pkg::*;
;
	// Short change pulse keeps the run brief
	localparam int CHG = 20;
	logic           SYS_CLK, SRST, OUTPUT_CHANGED, PROTECT;
	logic           inh_lvl, ext_lvl, trig_req, oe, tstart, irq, err;
	tcsp_apb_req_s  req;
	tcsp_apb_rsp_s  rsp;
	tcsp_pins_in_s  pin;
	tcsp_pins_out_s pout;
	logic [31:0]    q;
	int             error_cnt, n_tests;

	tcsp_port #(.CHG_PULSE_CYC(CHG)) i_tcsp_port (.SYS_CLK(SYS_CLK), .SRST(SRST),
		.APB_REQ(req), .APB_RSP(rsp), .PINS_IN(pin), .PINS_OUT(pout),
		.OUTPUT_CHANGED(OUTPUT_CHANGED), .PROTECT(PROTECT), .OUTPUT_ENABLE(oe),
		.TRANSIENT_START(tstart), .IRQ(irq));
	tcsp_ctl_model i_tcsp_ctl_model (.SYS_CLK(SYS_CLK), .INH_LVL(inh_lvl),
		.EXT_LVL(ext_lvl), .TRIG_REQ(trig_req), .PINS_IN(pin));

	initial begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
			error_cnt++;
		end
	endtask

	// One APB transfer; read data and error are taken at the pready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge SYS_CLK);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge SYS_CLK);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge SYS_CLK);
			i++;
		end while (rsp.pready !== 1'b1 && i < 50);
		if (rsp.pready !== 1'b1) begin
			chk("pready", 1'b1, rsp.pready);
			finish_test;
		end
		q = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("change_n", 1'b1, pout.change_n);
		chk("active", 1'b0, pout.output_active);
		chk("phase_single", 1'b1, pout.phase_single);
		chk("fault_n", 1'b1, pout.fault_n);
		chk("short_relay", 1'b0, pout.short_relay);
		chk("irq", 1'b0, irq);
	endtask

	task automatic t_ctrl;
		wr(`TCSP_OFF_CTRL, 32'h3);
		tick(2);
		chk("phase_single", 1'b0, pout.phase_single);
		chk("short_relay", 1'b1, pout.short_relay);
		rd(`TCSP_OFF_CTRL);
		chk("ctrl", 32'h3, q);
		chk("slverr", 1'b0, err);
		wr(`TCSP_OFF_CTRL, 32'h0);
		tick(2);
		chk("phase_single", 1'b1, pout.phase_single);
		chk("short_relay", 1'b0, pout.short_relay);
	endtask

	// Output on, then the external switch level taken away and back
	task automatic t_on;
		ext_lvl <= 1'b0;
		tick(6);
		wr(`TCSP_OFF_CMD, 32'h1);
		tick(2);
		chk("active", 1'b1, pout.output_active);
		chk("enable", 1'b1, oe);
		ext_lvl <= 1'b1;
		tick(6);
		chk("active", 1'b0, pout.output_active);
		ext_lvl <= 1'b0;
		tick(6);
		chk("active", 1'b1, pout.output_active);
	endtask

	// Halt latches: releasing the pin alone must not restart output
	task automatic t_halt;
		inh_lvl <= 1'b0;
		tick(6);
		chk("active", 1'b0, pout.output_active);
		rd(`TCSP_OFF_STATUS);
		chk("halt", 1'b1, q[`TCSP_ST_HALT]);
		wr(`TCSP_OFF_CMD, 32'h1);
		tick(2);
		chk("active", 1'b0, pout.output_active);
		inh_lvl <= 1'b1;
		tick(8);
		chk("active", 1'b0, pout.output_active);
		wr(`TCSP_OFF_CMD, 32'h1);
		tick(2);
		chk("active", 1'b1, pout.output_active);
	endtask

	task automatic t_trig;
		logic [7:0] s;
		int         n;
		rd(`TCSP_OFF_STATUS);
		s = q[15:8];
		trig_req <= 1'b1;
		tick(1);
		trig_req <= 1'b0;
		n = 0;
		repeat (12) begin
			tick(1);
			if (tstart === 1'b1) n++;
		end
		chk("starts", 1, n);
		rd(`TCSP_OFF_STATUS);
		chk("trig_cnt", {24'h0, s + 8'h1}, {24'h0, q[15:8]});
	endtask

	// Change pulse length from a single core event
	task automatic t_chg;
		int i;
		int n;
		tick(CHG * 2);
		@(posedge SYS_CLK);
		OUTPUT_CHANGED <= 1'b1;
		@(posedge SYS_CLK);
		OUTPUT_CHANGED <= 1'b0;
		#1;
		i = 0;
		while (pout.change_n !== 1'b0 && i < 10) begin
			tick(1);
			i++;
		end
		if (i >= 10) begin
			chk("change_n", 1'b0, pout.change_n);
			finish_test;
		end
		n = 0;
		while (pout.change_n === 1'b0 && n < 100) begin
			tick(1);
			n++;
		end
		chk("low_len", CHG, n);
		chk("change_n", 1'b1, pout.change_n);
	endtask

	// Protection with the interrupt masked, unmasked and cleared
	task automatic t_fault;
		wr(`TCSP_OFF_IRQ_MASK, 32'h0);
		wr(`TCSP_OFF_IRQ_STAT, 32'hf);
		@(posedge SYS_CLK);
		PROTECT <= 1'b1;
		tick(2);
		chk("fault_n", 1'b0, pout.fault_n);
		chk("active", 1'b0, pout.output_active);
		chk("irq", 1'b0, irq);
		wr(`TCSP_OFF_IRQ_MASK, 32'h8);
		tick(2);
		chk("irq", 1'b1, irq);
		rd(`TCSP_OFF_IRQ_STAT);
		chk("irq_stat", 1'b1, q[`TCSP_IRQ_FAULT]);
		@(posedge SYS_CLK);
		PROTECT <= 1'b0;
		wr(`TCSP_OFF_CMD, 32'h4);
		wr(`TCSP_OFF_IRQ_STAT, 32'h8);
		tick(2);
		chk("fault_n", 1'b1, pout.fault_n);
		chk("irq", 1'b0, irq);
		rd(12'hffc);
		chk("slverr", 1'b1, err);
		chk("unmapped", 32'h0, q);
	endtask

	// Reset in mid-run with output on and the control register set
	task automatic t_rerun;
		wr(`TCSP_OFF_CTRL, 32'h3);
		@(posedge SYS_CLK);
		SRST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		SRST <= 1'b0;
		#1;
		t_reset;
		wr(`TCSP_OFF_CMD, 32'h1);
		tick(4);
		chk("active", 1'b1, pout.output_active);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		SRST = 1'b1;
		req = '0;
		OUTPUT_CHANGED = 1'b0;
		PROTECT = 1'b0;
		inh_lvl = 1'b1;
		ext_lvl = 1'b1;
		trig_req = 1'b0;
		error_cnt = 0;
		n_tests = 0;
		repeat (2) @(posedge SYS_CLK);
		SRST <= 1'b0;
		tick(4);
		t_reset;
		t_ctrl;
		t_on;
		t_halt;
		t_trig;
		t_chg;
		t_fault;
		t_rerun;
		finish_test;
	end
endmodule
